// ---- pcl_pkg.sv ----
// package of constants for the program counter load logic
// assumes a single 50 MHz core clock and a plain register port
package pcl_pkg;
  localparam int PC_W = 15;
  localparam int SP_W = 5;
  localparam int DEPTH = 16;
  localparam logic [11:0] OFS_COUNTER_LOW = 12'h002;
  localparam logic [11:0] OFS_LATCH = 12'h00A;
  localparam logic [11:0] OFS_STACK_INDEX = 12'hFED;
  localparam logic [11:0] OFS_STACK_TOP_LOW = 12'hFEE;
  localparam logic [11:0] OFS_STACK_TOP_HIGH = 12'hFEF;
  localparam logic [4:0] STACK_INDEX_RESET = 5'h1F;
  localparam logic [6:0] LATCH_RESET = 7'h00;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [14:0] VECTOR_ADDR = 15'h0004;
  localparam int VEC_W = 4;
  // operation codes driven by the core sequencer each instruction
  typedef enum logic [2:0] {
    PCL_OP_NONE = 3'b000,
    PCL_OP_CALL = 3'b001,
    PCL_OP_COMPUTED_CALL = 3'b010,
    PCL_OP_INDEXED_BRANCH = 3'b011,
    PCL_OP_RELATIVE_BRANCH = 3'b100,
    PCL_OP_RET = 3'b101,
    PCL_OP_VECTOR = 3'b110,
    PCL_OP_GOTO = 3'b111
  } pcl_op_t;
endpackage

// ---- pcl_stack_if.sv ----
// interface between counter logic and the return stack
// assumes both ends run on the same clock
interface pcl_stack_if;
  logic push;
  logic pop;
  logic [14:0] push_data;
  logic [14:0] top;
  logic [4:0] index;
  logic index_we;
  logic [4:0] index_wdata;
  logic top_low_we;
  logic top_high_we;
  logic [7:0] top_wdata;
  modport ctrl (output push, pop, push_data, index_we, index_wdata, top_low_we, top_high_we,
    top_wdata, input top, index);
  modport stack (input push, pop, push_data, index_we, index_wdata, top_low_we, top_high_we,
    top_wdata, output top, index);
endinterface

// ---- pcl_stack.sv ----
// sixteen-level return stack with software reachable index and top
// assumes push and pop are never both high in one cycle
module pcl_stack (
  input wire logic clk, // core clock
  input wire logic rst, // async reset, active high
  pcl_stack_if.stack sif // stack port
);
  logic [14:0] mem [pcl_pkg::DEPTH];
  logic [4:0] index;
  wire [3:0] slot = index[3:0];
  wire [3:0] next_slot = 4'(index + 5'h01);

  // index resets to all ones: empty stack
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      index <= pcl_pkg::STACK_INDEX_RESET;
    end else if (sif.push) begin
      index <= index + 5'h01;
    end else if (sif.pop) begin
      index <= index - 5'h01;
    end else if (sif.index_we) begin
      index <= sif.index_wdata;
    end
  end

  // entries keep content over reset, so no reset term here
  always_ff @(posedge clk) begin
    if (sif.push) begin
      mem[next_slot] <= sif.push_data;
    end else if (sif.top_low_we) begin
      mem[slot][7:0] <= sif.top_wdata;
    end else if (sif.top_high_we) begin
      mem[slot][14:8] <= sif.top_wdata[6:0];
    end
  end

  assign sif.index = index;
  assign sif.top = mem[slot];
endmodule

// ---- pcl_core.sv ----
// program counter sequencing with low byte, latch and stack access
// assumes op strobes arrive one per fetched instruction from the core
module pcl_core (
  input wire logic clk, // core clock, 50 MHz
  input wire logic rst, // async reset, active high
  input wire logic fetch, // one instruction advances
  input wire pcl_pkg::pcl_op_t op, // flow change of this instruction
  input wire logic [10:0] operand, // call or goto target bits
  input wire logic [8:0] rel_offset, // signed branch offset
  input wire logic [7:0] accum, // accumulator value
  input wire logic [11:0] addr, // register address
  input wire logic [7:0] wdata, // register write data
  input wire logic wr, // register write strobe
  input wire logic rd, // register read strobe
  output logic [7:0] rdata, // register read data, cycle after rd
  output logic [14:0] pc, // program counter
  output logic [6:0] latch_out // current high address latch
);
  ////////////////////////////////////////////////////////////////
  // state
  logic [6:0] latch;
  logic [14:0] next_pc;
  pcl_stack_if sif();

  pcl_stack u_stack (
    .clk(clk),
    .rst(rst),
    .sif(sif)
  );

  ////////////////////////////////////////////////////////////////
  // register decode
  wire hit_low = (addr == pcl_pkg::OFS_COUNTER_LOW);
  wire hit_latch = (addr == pcl_pkg::OFS_LATCH);
  wire hit_index = (addr == pcl_pkg::OFS_STACK_INDEX);
  wire hit_top_low = (addr == pcl_pkg::OFS_STACK_TOP_LOW);
  wire hit_top_high = (addr == pcl_pkg::OFS_STACK_TOP_HIGH);
  wire wr_low = wr && hit_low;
  wire wr_latch = wr && hit_latch;

  // read mux; unmapped addresses read zero
  wire [7:0] rd_mux =
    hit_low ? pc[7:0] :
    hit_latch ? {1'b0, latch} :
    hit_index ? {3'b000, sif.index} :
    hit_top_low ? sif.top[7:0] :
    hit_top_high ? {1'b0, sif.top[14:8]} :
    8'h00;

  ////////////////////////////////////////////////////////////////
  // stack controls
  // a fetch lost to a low byte write must not move the stack either
  wire step = fetch && !wr_low;
  wire is_call = step && (op == pcl_pkg::PCL_OP_CALL || op == pcl_pkg::PCL_OP_COMPUTED_CALL);
  wire is_vector = step && (op == pcl_pkg::PCL_OP_VECTOR);
  wire is_ret = step && (op == pcl_pkg::PCL_OP_RET);
  wire [14:0] pc_inc = pc + 15'h0001;
  assign sif.push = is_call || is_vector;
  assign sif.pop = is_ret && !sif.push;
  // vectoring interrupts the current instruction, so its address returns
  assign sif.push_data = is_vector ? pc : pc_inc;
  assign sif.index_we = wr && hit_index;
  assign sif.index_wdata = wdata[4:0];
  assign sif.top_low_we = wr && hit_top_low;
  assign sif.top_high_we = wr && hit_top_high;
  assign sif.top_wdata = wdata;

  ////////////////////////////////////////////////////////////////
  // next counter value; a low byte write outranks flow
  // an indexed branch adds accum over all 15 bits, the carry propagates
  wire [14:0] idx_tgt = pc_inc + {7'h00, accum};
  wire [14:0] rel_tgt = pc_inc + {{6{rel_offset[8]}}, rel_offset};
  always_comb begin
    next_pc = pc;
    if (wr_low) begin
      next_pc = {latch, wdata};
    end else if (fetch) begin
      unique case (op)
        pcl_pkg::PCL_OP_CALL,
        pcl_pkg::PCL_OP_GOTO: next_pc = {latch[6:3], operand};
        pcl_pkg::PCL_OP_COMPUTED_CALL: next_pc = {latch, accum};
        pcl_pkg::PCL_OP_INDEXED_BRANCH: next_pc = idx_tgt;
        pcl_pkg::PCL_OP_RELATIVE_BRANCH: next_pc = rel_tgt;
        pcl_pkg::PCL_OP_RET: next_pc = sif.top;
        pcl_pkg::PCL_OP_VECTOR: next_pc = pcl_pkg::VECTOR_ADDR;
        pcl_pkg::PCL_OP_NONE: next_pc = pc_inc;
      endcase
    end
  end

  // counter clears on any reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc <= pcl_pkg::PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // latch is written only by software, untouched by stack traffic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch <= pcl_pkg::LATCH_RESET;
    end else if (wr_latch) begin
      latch <= wdata[6:0];
    end
  end

  // mirror follows the latch exactly, so the port never lags a write
  wire [6:0] next_latch_out = wr_latch ? wdata[6:0] : latch;

  // read data valid only in cycle after rd
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= pcl_pkg::RDATA_RESET;
      latch_out <= pcl_pkg::LATCH_RESET;
    end else begin
      rdata <= rd ? rd_mux : 8'h00;
      latch_out <= next_latch_out;
    end
  end
endmodule

// ---- pcl_core_chk.sv ----
// port checker for the program counter load logic
// assumes it is bound onto pcl_core, one clock, async reset
module pcl_core_chk (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic fetch, // advance
  input wire pcl_pkg::pcl_op_t op, // flow op
  input wire logic [10:0] operand, // target
  input wire logic [8:0] rel_offset, // offset
  input wire logic [7:0] accum, // acc
  input wire logic [11:0] addr, // address
  input wire logic [7:0] wdata, // data in
  input wire logic wr, // write
  input wire logic rd, // read
  input wire logic [7:0] rdata, // data out
  input wire logic [14:0] pc, // counter
  input wire logic [6:0] latch_out // latch
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a low byte write beats fetch, so flow checks skip that cycle
  wire logic low_wr = wr && addr == pcl_pkg::OFS_COUNTER_LOW;
  wire logic step = fetch && !low_wr;
  wire logic [3:0] latch_top = latch_out[6:3];
  wire logic [6:0] wd7 = wdata[6:0];
  wire logic [7:0] pc_lo = pc[7:0];
  wire logic [14:0] rel_ext = {{6{rel_offset[8]}}, rel_offset};
  sequence s_low;
    low_wr;
  endsequence
  ////////////////////////////////////////
  a_low_join: assert property (s_low |=> pc == {$past(latch_out), $past(wdata)})
    else $error("low write join wrong");
  a_plain_step: assert property (
    step && op == pcl_pkg::PCL_OP_NONE |=>
    pc == $past(pc) + 15'h0001)
    else $error("increment wrong");
  a_call_load: assert property (
    step && op == pcl_pkg::PCL_OP_CALL |=>
    pc == {$past(latch_top), $past(operand)})
    else $error("call target wrong");
  a_computed_load: assert property (
    step && op == pcl_pkg::PCL_OP_COMPUTED_CALL |=>
    pc == {$past(latch_out), $past(accum)})
    else $error("computed call wrong");
  a_index_sum: assert property (
    step && op == pcl_pkg::PCL_OP_INDEXED_BRANCH |=>
    pc == $past(pc) + 15'h0001 + $past(accum))
    else $error("indexed branch wrong");
  a_relative_sum: assert property (
    step && op == pcl_pkg::PCL_OP_RELATIVE_BRANCH |=>
    pc == $past(pc) + 15'h0001 + $past(rel_ext))
    else $error("relative branch wrong");
  a_low_read: assert property (
    rd && addr == pcl_pkg::OFS_COUNTER_LOW |=> rdata == $past(pc_lo))
    else $error("low byte read wrong");
  a_latch_write: assert property (
    wr && addr == pcl_pkg::OFS_LATCH |=> latch_out == $past(wd7))
    else $error("latch write wrong");
endmodule
bind pcl_core pcl_core_chk chk (.clk, .rst, .fetch, .op, .operand, .rel_offset, .accum,
  .addr, .wdata, .wr, .rd, .rdata, .pc, .latch_out);

// ---- pcl_core_test.sv ----
// self-checking bench for the program counter load logic
// assumes pcl_core with its bound checker, 50 MHz clock
module pcl_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, fetch = 1'b0, wr = 1'b0, rd = 1'b0;
  pcl_pkg::pcl_op_t op = pcl_pkg::PCL_OP_NONE;
  logic [10:0] operand = 11'h000;
  logic [8:0] rel_offset = 9'h000;
  logic [7:0] accum = 8'h00, wdata = 8'h00, rdata;
  logic [11:0] addr = 12'h000;
  logic [14:0] pc;
  logic [6:0] latch_out;
  int failures = 0, checks = 0;
  pcl_core dut (.clk, .rst, .fetch, .op, .operand, .rel_offset, .accum, .addr, .wdata,
    .wr, .rd, .rdata, .pc, .latch_out);
  // 20 ns period
  initial forever #10 clk = ~clk;
  ////////////////////////////////////////
  task automatic same(string what, logic [14:0] exp, logic [14:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(logic [11:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(logic [11:0] a, logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 same("rdata", {7'h00, exp}, {7'h00, rdata});
  endtask
  // one value feeds operand, offset and accumulator to keep calls short
  task automatic go(pcl_pkg::pcl_op_t o, logic [10:0] v, logic [14:0] exp);
    @(posedge clk);
    fetch <= 1'b1;
    op <= o;
    operand <= v;
    rel_offset <= v[8:0];
    accum <= v[7:0];
    @(posedge clk);
    fetch <= 1'b0;
    #1 same("pc", exp, pc);
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // watchdog, far beyond the under one hundred cycles the tests need
  initial begin
    #20us;
    failures++;
    complete_run;
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1 same("pc", 15'h0000, pc);
    rd_reg(pcl_pkg::OFS_STACK_INDEX, 8'h1F);
    rd_reg(pcl_pkg::OFS_LATCH, 8'h00);
    wr_reg(pcl_pkg::OFS_LATCH, 8'h12);
    wr_reg(pcl_pkg::OFS_COUNTER_LOW, 8'h34);
    same("pc", 15'h1234, pc);
    rd_reg(pcl_pkg::OFS_COUNTER_LOW, 8'h34);
    rd_reg(12'h123, 8'h00);
    go(pcl_pkg::PCL_OP_NONE, 11'h000, 15'h1235);
    $display("low byte test done");
    go(pcl_pkg::PCL_OP_CALL, 11'h7AB, 15'h17AB);
    rd_reg(pcl_pkg::OFS_STACK_INDEX, 8'h00);
    rd_reg(pcl_pkg::OFS_STACK_TOP_LOW, 8'h36);
    rd_reg(pcl_pkg::OFS_STACK_TOP_HIGH, 8'h12);
    go(pcl_pkg::PCL_OP_COMPUTED_CALL, 11'h080, 15'h1280);
    go(pcl_pkg::PCL_OP_RET, 11'h000, 15'h17AC);
    go(pcl_pkg::PCL_OP_RET, 11'h000, 15'h1236);
    rd_reg(pcl_pkg::OFS_STACK_INDEX, 8'h1F);
    same("latch_out", 15'h0012, {8'h00, latch_out});
    $display("call test done");
    go(pcl_pkg::PCL_OP_INDEXED_BRANCH, 11'h0FF, 15'h1336);
    go(pcl_pkg::PCL_OP_RELATIVE_BRANCH, 11'h100, 15'h1237);
    go(pcl_pkg::PCL_OP_RELATIVE_BRANCH, 11'h0FF, 15'h1337);
    go(pcl_pkg::PCL_OP_VECTOR, 11'h000, 15'h0004);
    rd_reg(pcl_pkg::OFS_STACK_TOP_LOW, 8'h37);
    wr_reg(pcl_pkg::OFS_STACK_TOP_HIGH, 8'hFF);
    rd_reg(pcl_pkg::OFS_STACK_TOP_HIGH, 8'h7F);
    go(pcl_pkg::PCL_OP_GOTO, 11'h0AB, 15'h10AB);
    $display("branch test done");
    wr_reg(pcl_pkg::OFS_LATCH, 8'hFF);
    rd_reg(pcl_pkg::OFS_LATCH, 8'h7F);
    wr_reg(pcl_pkg::OFS_COUNTER_LOW, 8'hFF);
    go(pcl_pkg::PCL_OP_NONE, 11'h000, 15'h0000);
    $display("wrap test done");
    // table jump by low byte arithmetic: the carry is software's job
    wr_reg(pcl_pkg::OFS_LATCH, 8'h12);
    wr_reg(pcl_pkg::OFS_COUNTER_LOW, 8'hF0);
    same("pc", 15'h12F0, pc);
    wr_reg(pcl_pkg::OFS_COUNTER_LOW, 8'h10);
    same("pc", 15'h1210, pc);
    wr_reg(pcl_pkg::OFS_LATCH, 8'h13);
    wr_reg(pcl_pkg::OFS_COUNTER_LOW, 8'h10);
    same("pc", 15'h1310, pc);
    same("latch_out", 15'h0013, {8'h00, latch_out});
    $display("block crossing test done");
    // second reset: counter and latch clear, stack entries survive
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 same("pc", 15'h0000, pc);
    same("latch_out", 15'h0000, {8'h00, latch_out});
    rd_reg(pcl_pkg::OFS_STACK_INDEX, 8'h1F);
    wr_reg(pcl_pkg::OFS_STACK_INDEX, 8'h00);
    rd_reg(pcl_pkg::OFS_STACK_TOP_HIGH, 8'h7F);
    rd_reg(pcl_pkg::OFS_STACK_TOP_LOW, 8'h37);
    $display("second reset test done");
    complete_run;
  end
endmodule
